//--- line_to_drive_transfer_sequencer.sv
// sequencer moving a line-fed motor onto the drive, with wishbone registers
// assumes contactor flags come from an external controller, drive status is
// synchronous except the single-bit flags, which are synchronised here
`timescale 1ns/10ps
`default_nettype none
module line_to_drive_transfer_sequencer
  import xfer_pkg::*;
#(
  parameter int unsigned TW        = 16,
  parameter int unsigned MS_CNT    = MS_CYCLES,
  parameter int unsigned MATCH_CNT = MATCH_CYC,
  parameter int unsigned GAP_CNT   = GAP_CYC,
  parameter int unsigned PLL_CNT   = PLL_CYC
) (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // wishbone slave
  input  wire logic          cyc_i,
  input  wire logic          stb_i,
  input  wire logic          we_i,
  input  wire logic [7:0]    adr_i,
  input  wire logic [3:0]    sel_i,
  input  wire logic [31:0]   dat_i,
  output logic      [31:0]   dat_o,
  output logic               ack_o,
  // controller flags
  input  wire logic          line_to_drive_req_i,
  input  wire logic          run_req_i,
  input  wire logic          line_ack_i,
  input  wire logic          drive_ack_i,
  input  wire logic          fault_reset_i,
  // drive status
  input  wire logic          fault_i,
  input  wire logic          hard_inhibit_input_i,
  input  wire logic          pll_locked_i,
  input  wire logic          freq_match_i,
  input  wire logic [TW-1:0] out_volt_cap_i,
  input  wire logic [TW-1:0] line_volt_i,
  input  wire logic [TW-1:0] torque_cur_i,
  // handshake outputs
  output logic               line_to_drive_permit_o,
  output logic               line_contactor_release_o,
  output logic               line_to_drive_done_o,
  output logic               low_output_voltage_flag_o,
  // drive control outputs
  output logic               gate_enable_o,
  output logic [TW-1:0]      torque_cmd_o,
  output logic               follow_setpoint_o,
  output logic [2:0]         xfer_state_o,
  output logic               xfer_fail_warn_o,
  output logic               timeout_alarm_o
);
  // ************************************************
  // declarations
  // ************************************************
  logic [N_SYNC-1:0] meta_reg;
  logic [N_SYNC-1:0] sync_reg;
  xfer_state_type    xst_reg;
  drive_state_type   drv_reg;
  logic              permit_reg;
  logic              release_reg;
  logic              done_reg;
  logic              lowv_reg;
  logic              gate_reg;
  logic              follow_reg;
  logic              fault_lat_reg;
  logic              warn_reg;
  logic              alarm_reg;
  logic [TW-1:0]     tcmd_reg;
  logic [2:0]        hs_prev_reg;
  logic [31:0]       ms_cnt_reg;
  logic [15:0]       tout_ms_reg;
  logic              spin_en_reg;
  logic [15:0]       timeout_reg;
  logic [15:0]       tmax_reg;
  logic              ack_reg;
  logic [31:0]       dat_reg;
  logic              req_s, run_s, lak_s, dak_s, frs_s;
  logic              flt_s, inh_s, pll_s, fm_s;
  logic              gap_ok, pll_ok, match_ok;
  logic              ms_tick, tout_hit, start_ok, abort;
  logic              wb_req, wr_en, clr_req;
  logic [TW-1:0]     torq_thresh;

  // ************************************************
  // functions
  // ************************************************
  // byte-lane merge for the 16-bit writable registers
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [1:0]  lanes);
    logic [15:0] r;
    r = old_v;
    if (lanes[0]) begin
      r[7:0] = new_v[7:0];
    end
    if (lanes[1]) begin
      r[15:8] = new_v[15:8];
    end
    return r;
  endfunction

  // ************************************************
  // input synchronisers
  // ************************************************
  // two-stage flag sync
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= {freq_match_i, pll_locked_i, hard_inhibit_input_i, fault_i,
                   fault_reset_i, drive_ack_i, line_ack_i, run_req_i,
                   line_to_drive_req_i};
      sync_reg <= meta_reg;
    end
  end

  assign req_s = sync_reg[S_REQ];
  assign run_s = sync_reg[S_RUN];
  assign lak_s = sync_reg[S_LAK];
  assign dak_s = sync_reg[S_DAK];
  assign frs_s = sync_reg[S_FRS];
  assign flt_s = sync_reg[S_FLT];
  assign inh_s = sync_reg[S_INH];
  assign pll_s = sync_reg[S_PLL];
  assign fm_s  = sync_reg[S_FM];

  // ************************************************
  // timers
  // ************************************************
  // spacing between handshake edges
  hold_timer #(.COUNT(GAP_CNT)) u_gap (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .hold_i ({permit_reg, release_reg, done_reg} == hs_prev_reg),
    .done_o (gap_ok)
  );

  // pll settle after drive contactor closes
  hold_timer #(.COUNT(PLL_CNT)) u_pll (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .hold_i (dak_s && drv_reg == DRV_XFER),
    .done_o (pll_ok)
  );

  // frequency match held while on line
  hold_timer #(.COUNT(MATCH_CNT)) u_match (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .hold_i (fm_s && lak_s && xst_reg == XS_LOCK),
    .done_o (match_ok)
  );

  // previous handshake vector, so any edge restarts the spacing timer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hs_prev_reg <= 3'h0;
    end else begin
      hs_prev_reg <= {permit_reg, release_reg, done_reg};
    end
  end

  // millisecond tick; 32-bit count keeps long periods exact
  assign ms_tick = (ms_cnt_reg == MS_CNT - 1);
  always_ff @(posedge clk_i) begin
    if (rst_i || ms_tick) begin
      ms_cnt_reg <= 32'h0;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 32'h1;
    end
  end

  // transfer timeout in ms, zero disables
  always_ff @(posedge clk_i) begin
    if (rst_i || drv_reg != DRV_XFER || xst_reg == XS_DONE) begin
      tout_ms_reg <= 16'h0;
    end else if (ms_tick && tout_ms_reg != 16'hFFFF) begin
      tout_ms_reg <= tout_ms_reg + 16'h1;
    end
  end
  assign tout_hit = (drv_reg == DRV_XFER) && (xst_reg != XS_DONE)
                    && (timeout_reg != 16'h0) && (tout_ms_reg >= timeout_reg);

  // ************************************************
  // main sequencing
  // ************************************************
  assign torq_thresh = tmax_reg[TW-1:0] >> TORQ_SHIFT;
  // entry only from idle with spinning load on
  assign start_ok = spin_en_reg && req_s && run_s && lak_s && !warn_reg
                    && !fault_lat_reg && !flt_s && !inh_s;
  // run removal, fault, inhibit or transfer timeout abort at once
  assign abort = flt_s || inh_s || !run_s || tout_hit;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drv_reg     <= DRV_IDLE;
      xst_reg     <= XS_INIT;
      permit_reg  <= 1'b0;
      release_reg <= 1'b0;
      done_reg    <= 1'b0;
      lowv_reg    <= 1'b0;
      gate_reg    <= 1'b0;
      follow_reg  <= 1'b0;
    end else begin
      case (drv_reg)
        DRV_IDLE: begin
          if (start_ok) begin
            // refuse when output cannot reach line voltage
            if (out_volt_cap_i < line_volt_i) begin
              lowv_reg <= 1'b1;
            end else if (gap_ok) begin
              permit_reg <= 1'b1;
              lowv_reg   <= 1'b0;
              drv_reg    <= DRV_XFER;
              xst_reg    <= XS_INIT;
            end
          end else if (!req_s) begin
            lowv_reg <= 1'b0;
          end
        end
        DRV_XFER: begin
          if (abort) begin
            drv_reg     <= DRV_IDLE;
            xst_reg     <= XS_INIT;
            permit_reg  <= 1'b0;
            release_reg <= 1'b0;
            done_reg    <= 1'b0;
            gate_reg    <= 1'b0;
          end else begin
            case (xst_reg)
              XS_INIT: begin
                // lock once pll settles, gates on
                if (pll_ok && pll_s) begin
                  xst_reg  <= XS_LOCK;
                  gate_reg <= 1'b1;
                end
              end
              XS_LOCK: begin
                if (match_ok) begin
                  xst_reg <= XS_TORQ;
                end
              end
              XS_TORQ: begin
                // quarter torque, ask for line release
                if (torque_cur_i >= torq_thresh && gap_ok) begin
                  xst_reg     <= XS_OPENW;
                  release_reg <= 1'b1;
                end
              end
              XS_OPENW: begin
                if (!lak_s && gap_ok) begin
                  xst_reg  <= XS_DONE;
                  done_reg <= 1'b1;
                end
              end
              XS_DONE: begin
                if (!req_s && gap_ok) begin
                  permit_reg  <= 1'b0;
                  release_reg <= 1'b0;
                  done_reg    <= 1'b0;
                  follow_reg  <= 1'b1;
                  drv_reg     <= DRV_RUN;
                  xst_reg     <= XS_INIT;
                end
              end
              default: begin
                xst_reg <= XS_INIT;
              end
            endcase
          end
        end
        DRV_RUN: begin
          if (flt_s || inh_s || !run_s) begin
            drv_reg    <= DRV_IDLE;
            gate_reg   <= 1'b0;
            follow_reg <= 1'b0;
          end
        end
        default: begin
          drv_reg <= DRV_IDLE;
        end
      endcase
    end
  end

  // torque ramp toward the permissible maximum
  always_ff @(posedge clk_i) begin
    if (rst_i || !gate_reg) begin
      tcmd_reg <= '0;
    end else if (xst_reg == XS_TORQ && tcmd_reg < tmax_reg[TW-1:0]) begin
      tcmd_reg <= tcmd_reg + TORQ_STEP[TW-1:0];
    end
  end

  // fault latch held until fault reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_lat_reg <= 1'b0;
    end else if (flt_s) begin
      fault_lat_reg <= 1'b1;
    end else if (frs_s) begin
      fault_lat_reg <= 1'b0;
    end
  end

  // sticky warning and alarm; set beats clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      warn_reg  <= 1'b0;
      alarm_reg <= 1'b0;
    end else if (tout_hit) begin
      warn_reg  <= 1'b1;
      alarm_reg <= 1'b1;
    end else if (clr_req) begin
      warn_reg  <= 1'b0;
      alarm_reg <= 1'b0;
    end
  end

  // ************************************************
  // wishbone slave
  // ************************************************
  // one wait state; the write lands on the edge the master sees ack
  assign wb_req  = cyc_i && stb_i;
  assign wr_en   = wb_req && we_i && ack_reg;
  assign clr_req = wr_en && adr_i == ADR_CTRL && sel_i[0] && dat_i[CTRL_CLR];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_req && !ack_reg;
    end
  end

  // writable registers, unmapped writes dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      spin_en_reg <= 1'b0;
      timeout_reg <= TIMEOUT_RST;
      tmax_reg    <= TMAX_RST;
    end else if (wr_en) begin
      if (adr_i == ADR_CTRL) begin
        if (sel_i[0]) begin
          spin_en_reg <= dat_i[CTRL_SPIN];
        end
      end else if (adr_i == ADR_TIMEOUT) begin
        timeout_reg <= merge16(timeout_reg, dat_i[15:0], sel_i[1:0]);
      end else if (adr_i == ADR_TMAX) begin
        tmax_reg <= merge16(tmax_reg, dat_i[15:0], sel_i[1:0]);
      end
    end
  end

  // read data captured with the request; unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_reg <= 32'h0;
    end else if (wb_req && !ack_reg) begin
      if (adr_i == ADR_CTRL) begin
        dat_reg <= {31'h0, spin_en_reg};
      end else if (adr_i == ADR_TIMEOUT) begin
        dat_reg <= {16'h0, timeout_reg};
      end else if (adr_i == ADR_TMAX) begin
        dat_reg <= {16'h0, tmax_reg};
      end else if (adr_i == ADR_STATUS) begin
        dat_reg <= {20'h0, drv_reg, fault_lat_reg, alarm_reg, warn_reg,
                    lowv_reg, done_reg, release_reg, permit_reg, xst_reg};
      end else begin
        dat_reg <= 32'h0;
      end
    end
  end

  // ************************************************
  // outputs
  // ************************************************
  // state code driven straight out
  assign xfer_state_o              = xst_reg;
  assign dat_o                     = dat_reg;
  assign ack_o                     = ack_reg;
  assign line_to_drive_permit_o    = permit_reg;
  assign line_contactor_release_o  = release_reg;
  assign line_to_drive_done_o      = done_reg;
  assign low_output_voltage_flag_o = lowv_reg;
  assign gate_enable_o             = gate_reg;
  assign torque_cmd_o              = tcmd_reg;
  assign follow_setpoint_o         = follow_reg;
  assign xfer_fail_warn_o          = warn_reg;
  assign timeout_alarm_o           = alarm_reg;

  // ************************************************
  // assertions
  // ************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_state_code;
    xst_reg inside {XS_INIT, XS_LOCK, XS_TORQ, XS_OPENW, XS_DONE};
  endproperty
  a_state_code: assert property (p_state_code) else $error("bad state code");

  property p_refuse_low;
    drv_reg == DRV_IDLE && start_ok && out_volt_cap_i < line_volt_i
      |=> lowv_reg && drv_reg == DRV_IDLE && !permit_reg;
  endproperty
  a_refuse_low: assert property (p_refuse_low) else $error("low volt entry");

  property p_gate_on_lock;
    xst_reg == XS_INIT ##1 xst_reg == XS_LOCK |-> gate_reg;
  endproperty
  a_gate_on_lock: assert property (p_gate_on_lock) else $error("gates off");

  property p_release_wait;
    xst_reg == XS_OPENW |-> release_reg && permit_reg;
  endproperty
  a_release_wait: assert property (p_release_wait) else $error("no release");

  property p_done_wait;
    xst_reg == XS_OPENW && !lak_s && gap_ok && !abort
      |=> xst_reg == XS_DONE && done_reg;
  endproperty
  a_done_wait: assert property (p_done_wait) else $error("no done");

  property p_abort;
    drv_reg == DRV_XFER && (flt_s || inh_s || !run_s)
      |=> !gate_reg && drv_reg == DRV_IDLE && !permit_reg && !release_reg;
  endproperty
  a_abort: assert property (p_abort) else $error("abort late");

  property p_timeout;
    tout_hit |=> warn_reg && alarm_reg && xst_reg == XS_INIT ##1 !permit_reg;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout lost");

  property p_gap;
    $rose(release_reg) || $rose(done_reg) |-> $past(gap_ok);
  endproperty
  a_gap: assert property (p_gap) else $error("handshake too close");

  property p_fault_block;
    fault_lat_reg && drv_reg == DRV_IDLE |=> drv_reg == DRV_IDLE;
  endproperty
  a_fault_block: assert property (p_fault_block) else $error("ran on fault");

  property p_wb_ack;
    wb_req && !ack_reg |=> ack_reg ##1 !ack_reg;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("bus ack shape");

  c_enter: cover property (drv_reg == DRV_IDLE ##1 drv_reg == DRV_XFER);
  c_done: cover property (xst_reg == XS_DONE ##1 drv_reg == DRV_RUN);
  c_tout: cover property (tout_hit);
  c_lowv: cover property ($rose(lowv_reg));
endmodule
`default_nettype wire

//--- xfer_pkg.sv
// constants, register map and timing for the line-to-drive transfer sequencer
// assumes a 200 MHz control clock; shared by the sequencer and its test bench
package xfer_pkg;
  // ************************************************
  // timing
  // ************************************************
  localparam int unsigned CLK_HZ     = 200_000_000;
  localparam int unsigned MS_CYCLES  = CLK_HZ / 1000;
  localparam int unsigned MATCH_MS   = 1000;
  localparam int unsigned GAP_MS     = 250;
  localparam int unsigned PLL_MS     = 5000;
  localparam int unsigned MATCH_CYC  = MS_CYCLES * MATCH_MS;
  localparam int unsigned GAP_CYC    = MS_CYCLES * GAP_MS;
  localparam int unsigned PLL_CYC    = MS_CYCLES * PLL_MS;
  localparam int unsigned TORQ_SHIFT = 2;
  // ************************************************
  // register map
  // ************************************************
  localparam logic [7:0]  ADR_CTRL     = 8'h00;
  localparam logic [7:0]  ADR_TIMEOUT  = 8'h04;
  localparam logic [7:0]  ADR_TMAX     = 8'h08;
  localparam logic [7:0]  ADR_STATUS   = 8'h0C;
  localparam int unsigned CTRL_SPIN    = 0;
  localparam int unsigned CTRL_CLR     = 1;
  localparam logic [15:0] TIMEOUT_RST  = 16'h2710;
  localparam logic [15:0] TMAX_RST     = 16'h1000;
  localparam logic [15:0] TORQ_STEP    = 16'h0001;
  // ************************************************
  // synchroniser bit positions
  // ************************************************
  localparam int unsigned S_REQ = 0;
  localparam int unsigned S_RUN = 1;
  localparam int unsigned S_LAK = 2;
  localparam int unsigned S_DAK = 3;
  localparam int unsigned S_FRS = 4;
  localparam int unsigned S_FLT = 5;
  localparam int unsigned S_INH = 6;
  localparam int unsigned S_PLL = 7;
  localparam int unsigned S_FM  = 8;
  localparam int unsigned N_SYNC = 9;
  // ************************************************
  // states
  // ************************************************
  typedef enum logic [2:0] {
    XS_INIT  = 3'h0,
    XS_LOCK  = 3'h1,
    XS_TORQ  = 3'h3,
    XS_OPENW = 3'h5,
    XS_DONE  = 3'h6
  } xfer_state_type;
  typedef enum logic [1:0] {
    DRV_IDLE = 2'h0,
    DRV_XFER = 2'h1,
    DRV_RUN  = 2'h3
  } drive_state_type;
endpackage

//--- hold_timer.sv
// counter that reports when a condition has held for a set number of cycles
// assumes the condition is already synchronous to clk_i
`timescale 1ns/10ps
`default_nettype none
module hold_timer #(
  parameter int unsigned COUNT = 1
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // condition and result
  input  wire logic hold_i,
  output logic      done_o
);
  logic [31:0] cnt_reg;

  // restart whenever the condition drops; saturate at the target
  always_ff @(posedge clk_i) begin
    if (rst_i || !hold_i) begin
      cnt_reg <= 32'h0;
    end else if (cnt_reg < COUNT) begin
      cnt_reg <= cnt_reg + 32'h1;
    end
  end

  assign done_o = hold_i && (cnt_reg == COUNT);
endmodule
`default_nettype wire

//--- plc_model.sv
// controller model: transfer request, run and contactor acknowledges
// assumes sequencer flags are synchronous to clk_i; go_i starts a sequence
`timescale 1ns/10ps
`default_nettype none
module plc_model #(
  parameter int GAP = 8
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // bench command and sequencer flags
  input  wire logic go_i,
  input  wire logic permit_i,
  input  wire logic release_i,
  input  wire logic done_i,
  // contactor flags
  output logic      req_o,
  output logic      run_o,
  output logic      line_ack_o,
  output logic      drive_ack_o
);
  int gap_cnt;
  // one flag change per step; slow answers come from a larger GAP
  always_ff @(posedge clk_i) begin
    if (rst_i || !go_i) begin
      req_o       <= 1'b0;
      run_o       <= 1'b0;
      line_ack_o  <= 1'b1;
      drive_ack_o <= 1'b0;
      gap_cnt     <= GAP;
    end else if (gap_cnt != 0) begin
      gap_cnt <= gap_cnt - 1;
    end else begin
      gap_cnt <= GAP;
      if (!req_o && !drive_ack_o)
        req_o <= 1'b1;
      else if (!run_o)
        run_o <= 1'b1;
      else if (permit_i && !drive_ack_o)
        drive_ack_o <= 1'b1;
      else if (release_i && line_ack_o)
        line_ack_o <= 1'b0;
      else if (done_i && req_o)
        req_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- line_to_drive_transfer_sequencer_test.sv
// self-checking bench for the transfer sequencer
// assumes shortened counts; the controller model answers each step
`timescale 1ns/10ps
`default_nettype none
module line_to_drive_transfer_sequencer_test import xfer_pkg::*;;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0;
  logic        fault = 1'b0, inh = 1'b0, frst = 1'b0, pll = 1'b1, fm = 1'b1;
  logic [3:0]  sel = 4'h0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0, rd, dat_o;
  logic [15:0] ocap = 16'h0100, lvolt = 16'h0080, tcur = 16'h0000, tcmd, t0;
  logic        ack, req, run, lack, dack, permit, rel, done, lowv, gate, follow, warn, alarm;
  logic [2:0]  st;
  int          mismatches = 0, checks_done = 0;
  always #2.5 clk_i = ~clk_i;
  line_to_drive_transfer_sequencer #(.MS_CNT(10), .MATCH_CNT(20), .GAP_CNT(8), .PLL_CNT(30)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack), .line_to_drive_req_i(req),
    .run_req_i(run), .line_ack_i(lack), .drive_ack_i(dack), .fault_reset_i(frst),
    .fault_i(fault), .hard_inhibit_input_i(inh), .pll_locked_i(pll), .freq_match_i(fm),
    .out_volt_cap_i(ocap), .line_volt_i(lvolt), .torque_cur_i(tcur),
    .line_to_drive_permit_o(permit), .line_contactor_release_o(rel),
    .line_to_drive_done_o(done), .low_output_voltage_flag_o(lowv), .gate_enable_o(gate),
    .torque_cmd_o(tcmd), .follow_setpoint_o(follow), .xfer_state_o(st),
    .xfer_fail_warn_o(warn), .timeout_alarm_o(alarm));
  plc_model #(.GAP(8)) plc (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .permit_i(permit),
    .release_i(rel), .done_i(done), .req_o(req), .run_o(run), .line_ack_o(lack),
    .drive_ack_o(dack));
  // ****************
  // helpers
  // ****************
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // single classic cycle, held until ack is sampled
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hF;
    n = 0;
    do @(posedge clk_i); while (ack !== 1'b1 && ++n < 50);
    chk("bus ack", 16'h1, {15'h0, ack});
    rd = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk_i);
  endtask
  task wait_st(input logic [2:0] s);
    for (int n = 0; n < 400 && st !== s; n++) @(posedge clk_i);
    chk("state", {13'h0, s}, {13'h0, st});
  endtask
  // ****************
  // scenarios
  // ****************
  task test_regs;
    chk("reset outs", 16'h0, {5'h0, st, permit, rel, done, lowv, gate, follow, warn, alarm});
    wb(1'b0, ADR_TIMEOUT, 32'h0);
    chk("timeout reg", TIMEOUT_RST, rd[15:0]);
    wb(1'b0, ADR_TMAX, 32'h0);
    chk("tmax reg", TMAX_RST, rd[15:0]);
    wb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 16'h0, rd[15:0]);
    go <= 1'b1;
    repeat (100) @(posedge clk_i);
    chk("permit spin off", 16'h0, {15'h0, permit});
    go <= 1'b0;
    wb(1'b1, ADR_CTRL, 32'h1);
    wb(1'b1, ADR_TMAX, 32'h40);
    wb(1'b1, ADR_TIMEOUT, 32'h0);
  endtask
  task test_low_volt;
    ocap <= 16'h007F;
    go <= 1'b1;
    repeat (100) @(posedge clk_i);
    chk("low volt flag", 16'h1, {15'h0, lowv});
    chk("permit low volt", 16'h0, {15'h0, permit});
    go <= 1'b0;
    ocap <= 16'h0080;
    repeat (20) @(posedge clk_i);
  endtask
  task test_full;
    pll <= 1'b0;
    fm <= 1'b0;
    go <= 1'b1;
    repeat (150) @(posedge clk_i);
    chk("pll wait", 16'h0, {12'h0, st, gate});
    pll <= 1'b1;
    wait_st(3'h1);
    chk("gate on", 16'h1, {15'h0, gate});
    chk("permit", 16'h1, {15'h0, permit});
    repeat (60) @(posedge clk_i);
    chk("match wait", 16'h1, {13'h0, st});
    fm <= 1'b1;
    wait_st(3'h3);
    t0 = tcmd;
    repeat (3) @(posedge clk_i);
    chk("torque ramp", t0 + 16'h3, tcmd);
    chk("early release", 16'h0, {15'h0, rel});
    tcur <= 16'h0010;
    wait_st(3'h5);
    chk("release", 16'h1, {15'h0, rel});
    wait_st(3'h6);
    chk("done", 16'h1, {15'h0, done});
    wait_st(3'h0);
    chk("follow", 16'h1, {15'h0, follow});
    chk("exit flags", 16'h0, {14'h0, permit, rel});
    go <= 1'b0;
    tcur <= 16'h0000;
    repeat (20) @(posedge clk_i);
  endtask
  // kind 0 run removed, 1 hard inhibit, 2 drive fault
  task test_abort(input int kind);
    go <= 1'b1;
    wait_st(3'h1);
    if (kind == 0) go <= 1'b0;
    if (kind == 1) inh <= 1'b1;
    if (kind == 2) fault <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk("abort gate", 16'h0, {15'h0, gate});
    chk("abort flags", 16'h0, {11'h0, st, permit, rel});
    go <= 1'b0;
    repeat (20) @(posedge clk_i);
    inh <= 1'b0;
    fault <= 1'b0;
    go <= 1'b1;
    repeat (100) @(posedge clk_i);
    chk("permit again", {15'h0, kind != 2}, {15'h0, permit});
    go <= 1'b0;
    frst <= 1'b1;
    repeat (4) @(posedge clk_i);
    frst <= 1'b0;
    go <= 1'b1;
    repeat (100) @(posedge clk_i);
    chk("permit reset", 16'h1, {15'h0, permit});
    go <= 1'b0;
    repeat (20) @(posedge clk_i);
  endtask
  task test_timeout;
    wb(1'b1, ADR_TIMEOUT, 32'h1);
    go <= 1'b1;
    for (int n = 0; n < 200 && warn !== 1'b1; n++) @(posedge clk_i);
    chk("warn alarm", 16'h3, {14'h0, warn, alarm});
    chk("timeout state", 16'h0, {13'h0, st});
    go <= 1'b0;
    repeat (20) @(posedge clk_i);
    go <= 1'b1;
    repeat (100) @(posedge clk_i);
    chk("permit blocked", 16'h0, {15'h0, permit});
    go <= 1'b0;
    wb(1'b1, ADR_CTRL, 32'h3);
    wb(1'b0, ADR_STATUS, 32'h0);
    chk("warn cleared", 16'h0, {14'h0, rd[8:7]});
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // main sequence, then the watchdog
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    test_regs();
    test_low_volt();
    test_full();
    for (int k = 0; k < 3; k++) test_abort(k);
    test_timeout();
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    print_verdict();
  end
endmodule
`default_nettype wire
